// ---- src/hpb_defs.vh ----
// Constants for the host port pin block.
// Assumes inclusion by bare name from the block's design files.
// Behaviour
// (RULE1) Byte-id pin acts as host function only if strap high at reset.
// (RULE2) Host drives byte-id to mark first or second byte in multiplexed mode.
// (RULE3) Two select bits choose control, data-increment, address or data register.
// (RULE4) Port answers only while active-low port select is low.
// (RULE5) Host starts no transfer before the port leaves reset.
// (RULE6) Read/write select sets access direction; device reads or writes to match.
// (RULE7) Data strobes time data in and out; device captures or presents with them.
// (RULE8) Select, port select, read/write and strobe pins are inputs after reset.
// (RULE9) Ready output tells host when next transfer can be accepted.
// (RULE10) Ready is high impedance in reset, driven 1 after release.
// (RULE11) Host interrupt is high impedance in reset, driven 1 after release.
// (RULE12) Port enable low disables port and floats all its outputs.
// (RULE13) Multiplexed host may latch address with the address strobe input.
// (RULE14) Pin functions are fixed at the release of reset.
`ifndef HPB_DEFS_VH
`define HPB_DEFS_VH
`define HPB_SEL_CONTROL 2'h0
`define HPB_SEL_DATA_INC 2'h1
`define HPB_SEL_ADDRESS 2'h2
`define HPB_SEL_DATA 2'h3
`define HPB_DATA_W 8
`define HPB_WORD_W 16
`define HPB_FIFO_DEPTH 16
`define HPB_CTRL_RESET 16'h0000
`define HPB_ADDR_RESET 16'h0000
`endif

// ---- src/hpb_fifo.v ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock, synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
module hpb_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clock,
    input wire rst,
    input wire ce,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output reg [WIDTH-1:0] out_data,
    output reg out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;
    wire load;
    assign in_ready = (count != DEPTH[AW:0]);
    assign push = in_valid && in_ready;
    // Output register refills when empty or being drained
    assign load = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);
    assign pop = load;

    always @(posedge clock)
    begin
        if (rst)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end
        else if (ce)
        begin
            if (push)
            begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                out_data <= mem[rd_ptr];
                rd_ptr <= rd_ptr + 1'b1;
                out_valid <= 1'b1;
            end
            else if (out_ready)
            begin
                out_valid <= 1'b0;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// ---- src/hpb_port.v ----
// Host port pin-level block: pin sync, strap capture, register select,
// two-byte word assembly into a write FIFO, read data, ready and interrupt pins.
// Assumes host pins are asynchronous; the DSP side drains writes and supplies reads.
`timescale 1ns/1ps
`include "hpb_defs.vh"
module hpb_port #(
    parameter DW = `HPB_DATA_W,
    parameter WW = `HPB_WORD_W,
    parameter DEPTH = `HPB_FIFO_DEPTH
) (
    input wire clock,
    input wire rst,
    input wire ce,
    input wire port_enable_pin,
    input wire boot_function_strap,
    input wire access_select_lo,
    input wire access_select_hi,
    input wire port_select_n,
    input wire read_write_select,
    input wire data_strobe_a,
    input wire data_strobe_b,
    input wire byte_half_id,
    input wire address_strobe_in,
    input wire [DW-1:0] host_data_in,
    output reg [DW-1:0] host_data_out,
    output wire host_data_oe,
    output wire host_ready_out,
    output wire host_ready_oe,
    output wire host_irq_out,
    output wire host_irq_oe,
    output wire shared_line_is_host,
    input wire dsp_irq_set,
    input wire dsp_irq_clear,
    output wire [WW-1:0] wr_data,
    output wire [WW-1:0] wr_addr,
    output wire wr_inc,
    output wire wr_valid,
    input wire wr_ready,
    output reg [WW-1:0] rd_addr,
    output reg rd_req,
    input wire [WW-1:0] rd_data,
    input wire rd_valid,
    output reg [WW-1:0] port_control_reg,
    output reg [WW-1:0] port_address_reg
);
    localparam ST_IDLE = 3'b001;
    localparam ST_BUSY = 3'b010;
    localparam ST_WAIT = 3'b100;
    localparam NS = 9;

    // Two-stage synchronisers; stage one feeds only stage two
    reg [NS-1:0] sync1;
    reg [NS-1:0] sync2;
    reg [DW-1:0] din1;
    reg [DW-1:0] din2;
    reg strobe_prev;
    reg as_prev;
    reg in_reset;
    reg host_mode;
    reg strap1;
    reg strap2;
    reg hi_byte;
    reg [DW-1:0] low_byte;
    reg [WW-1:0] rd_word;
    reg [DW-1:0] rd_hi_hold;
    reg [2:0] state;
    reg [2:0] next_state;
    reg irq_n;
    wire [WW-1:0] fifo_word;
    reg [WW+16:0] fifo_in;
    reg fifo_push;
    wire fifo_ready;
    wire [WW+16:0] fifo_out;
    wire sel_n;
    wire rw;
    wire strobe;
    wire bhid;
    wire astrobe;
    wire en;
    wire [1:0] sel;
    wire strobe_edge;
    wire access;
    wire cur_hi;

    always @(posedge clock)
    begin
        if (rst)
        begin
            sync1 <= 9'h081;
            sync2 <= 9'h081;
            din1 <= {DW{1'b0}};
            din2 <= {DW{1'b0}};
        end
        else if (ce)
        begin
            sync1 <= {port_enable_pin, address_strobe_in, byte_half_id, access_select_hi,
                      access_select_lo, read_write_select,
                      data_strobe_b, data_strobe_a, port_select_n};
            sync2 <= sync1;
            din1 <= host_data_in;
            din2 <= din1;
        end
    end

    assign sel_n = sync2[0];
    // Strobe is active when the two strobes differ (one low, one high)
    assign strobe = sync2[1] ^ sync2[2];
    assign rw = sync2[3];
    assign sel = sync2[5:4];
    assign bhid = sync2[6];
    assign astrobe = sync2[7];
    assign en = sync2[8];
    assign strobe_edge = strobe && !strobe_prev;
    assign access = strobe_edge && !sel_n && en && !in_reset; // RULE4 RULE12 RULE5
    // Byte order follows the byte-id pin when it is a host pin
    assign cur_hi = host_mode ? bhid : hi_byte; // RULE1 RULE2
    assign fifo_word = {din2, low_byte};

    // Strap synchronised, then caught while reset is held; fixed at release
    always @(posedge clock)
    begin
        if (ce)
        begin
            strap1 <= boot_function_strap;
            strap2 <= strap1;
            if (rst)
            begin
                host_mode <= strap2; // RULE1 RULE14
            end
        end
    end
    assign shared_line_is_host = host_mode;

    always @(posedge clock)
    begin
        if (rst)
        begin
            in_reset <= 1'b1;
        end
        else if (ce)
        begin
            in_reset <= 1'b0;
        end
    end

    // Outputs float during reset and while the port is disabled
    assign host_ready_oe = !rst && !in_reset && en; // RULE10 RULE12
    assign host_irq_oe = !rst && !in_reset && en; // RULE11 RULE12
    assign host_irq_out = irq_n;
    assign host_ready_out = (state == ST_IDLE) && fifo_ready; // RULE9 RULE10
    assign host_data_oe = en && !in_reset && !sel_n && rw && strobe; // RULE6 RULE7 RULE8

    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (access && rw && !cur_hi && sel != `HPB_SEL_CONTROL
                    && sel != `HPB_SEL_ADDRESS)
                begin
                    next_state = ST_BUSY;
                end
            ST_BUSY:
                next_state = ST_WAIT;
            ST_WAIT:
                if (rd_valid)
                begin
                    next_state = ST_IDLE;
                end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always @(posedge clock)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            strobe_prev <= 1'b0;
            as_prev <= 1'b1;
            hi_byte <= 1'b0;
            low_byte <= {DW{1'b0}};
            rd_word <= {WW{1'b0}};
            rd_hi_hold <= {DW{1'b0}};
            rd_req <= 1'b0;
            rd_addr <= `HPB_ADDR_RESET;
            host_data_out <= {DW{1'b0}};
            irq_n <= 1'b1;
            fifo_push <= 1'b0;
            fifo_in <= {(WW+17){1'b0}};
            port_control_reg <= `HPB_CTRL_RESET;
            port_address_reg <= `HPB_ADDR_RESET;
        end
        else if (ce)
        begin
            state <= next_state;
            strobe_prev <= strobe;
            as_prev <= astrobe;
            rd_req <= (state == ST_BUSY);
            // Set wins over clear
            if (dsp_irq_set)
            begin
                irq_n <= 1'b0;
            end
            else if (dsp_irq_clear)
            begin
                irq_n <= 1'b1;
            end
            if (fifo_ready)
            begin
                fifo_push <= 1'b0;
            end
            if (rd_valid && state == ST_WAIT)
            begin
                rd_word <= rd_data;
            end
            // Address strobe falling edge latches the address byte
            if (host_mode && as_prev && !astrobe && !sel_n && en)
            begin
                port_address_reg[DW-1:0] <= din2; // RULE13
            end
            if (access)
            begin
                hi_byte <= !cur_hi; // RULE1 RULE2
                if (rw)
                begin
                    case (sel) // RULE3 RULE6
                        `HPB_SEL_CONTROL:
                            host_data_out <= cur_hi ? port_control_reg[WW-1:DW]
                                                    : port_control_reg[DW-1:0];
                        `HPB_SEL_ADDRESS:
                            host_data_out <= cur_hi ? port_address_reg[WW-1:DW]
                                                    : port_address_reg[DW-1:0];
                        default:
                        begin
                            // Both halves come from the same fetched word
                            if (!cur_hi)
                            begin
                                rd_addr <= port_address_reg;
                                rd_hi_hold <= rd_word[WW-1:DW];
                            end
                            host_data_out <= cur_hi ? rd_hi_hold : rd_word[DW-1:0];
                            if (cur_hi && sel == `HPB_SEL_DATA_INC)
                            begin
                                port_address_reg <= port_address_reg + 1'b1;
                            end
                        end
                    endcase
                end
                else if (!cur_hi)
                begin
                    low_byte <= din2; // RULE7
                end
                else
                begin
                    case (sel) // RULE3
                        `HPB_SEL_CONTROL:
                            port_control_reg <= fifo_word;
                        `HPB_SEL_ADDRESS:
                            port_address_reg <= fifo_word;
                        default:
                        begin
                            fifo_push <= 1'b1;
                            fifo_in <= {(sel == `HPB_SEL_DATA_INC), port_address_reg,
                                        fifo_word};
                            if (sel == `HPB_SEL_DATA_INC)
                            begin
                                port_address_reg <= port_address_reg + 1'b1;
                            end
                        end
                    endcase
                end
            end
        end
    end

    hpb_fifo #(
        .WIDTH(WW + 17),
        .DEPTH(DEPTH),
        .AW(4)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .in_data(fifo_in),
        .in_valid(fifo_push),
        .in_ready(fifo_ready),
        .out_data(fifo_out),
        .out_valid(wr_valid),
        .out_ready(wr_ready)
    );
    assign wr_data = fifo_out[WW-1:0];
    assign wr_addr = fifo_out[WW+15:WW];
    assign wr_inc = fifo_out[WW+16];
endmodule

// ---- tb/hpb_port_props.sv ----
// Concurrent checks on the host port pin block's ports.
// Assumes it is bound onto hpb_port; the port names match its own.
`timescale 1ns/1ps
module hpb_port_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic port_enable_pin,
    input wire logic boot_function_strap,
    input wire logic port_select_n,
    input wire logic read_write_select,
    input wire logic host_data_oe,
    input wire logic host_ready_out,
    input wire logic host_ready_oe,
    input wire logic host_irq_out,
    input wire logic host_irq_oe,
    input wire logic shared_line_is_host,
    input wire logic dsp_irq_set,
    input wire logic [15:0] wr_data,
    input wire logic wr_valid,
    input wire logic wr_ready
);
    default clocking cb @(posedge clock);
    endclocking
    chk_ready_in_rst: assert property (rst && $past(rst) |-> !host_ready_oe)
        else $error("ready pin driven in reset");
    chk_irq_in_rst: assert property (rst && $past(rst) |-> !host_irq_oe)
        else $error("interrupt pin driven in reset");
    chk_pins_release: assert property ($fell(rst) && $past(port_enable_pin, 3)
        |-> ##[1:4] (host_ready_oe && host_ready_out && host_irq_oe && host_irq_out))
        else $error("ready or interrupt not driven high after reset");
    chk_disable_float: assert property (!port_enable_pin [*5]
        |-> !(host_ready_oe || host_irq_oe || host_data_oe)) else $error("output driven while off");
    chk_deselect_quiet: assert property (disable iff (rst) port_select_n [*5]
        |-> !host_data_oe) else $error("data driven while not selected");
    chk_write_quiet: assert property (disable iff (rst) !read_write_select [*5]
        |-> !host_data_oe) else $error("data driven during write");
    chk_strap_take: assert property ($fell(rst)
        |-> ##1 (shared_line_is_host == $past(boot_function_strap, 4)))
        else $error("strap not captured");
    chk_strap_hold: assert property (disable iff (rst) !$past(rst)
        |-> $stable(shared_line_is_host)) else $error("pin function changed after reset");
    chk_wr_hold: assert property (disable iff (rst) wr_valid && !wr_ready
        |=> wr_valid && $stable(wr_data)) else $error("write word dropped while stalled");
    chk_irq_raise: assert property (disable iff (rst) dsp_irq_set && port_enable_pin
        |-> ##[1:3] !host_irq_out) else $error("interrupt not raised");
    cover property (wr_valid && wr_ready);
    cover property (host_data_oe);
    cover property ($fell(host_irq_out));
endmodule

// ---- tb/hpb_dsp_model.sv ----
// DSP-side model: drains written words and answers read requests.
// Assumes one clock; stall holds the write side off.
`timescale 1ns/1ps
module hpb_dsp_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic stall,
    input wire logic [15:0] wr_data,
    input wire logic [15:0] wr_addr,
    input wire logic wr_inc,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [15:0] rd_addr,
    input wire logic rd_req,
    output logic [15:0] rd_data = 16'h0000,
    output logic rd_valid = 1'b0,
    output logic [15:0] last_data,
    output logic [15:0] last_addr,
    output logic last_inc,
    output int count
);
    assign wr_ready = !stall;
    // Read data is only meaningful with rd_valid; otherwise it keeps changing
    always @(posedge clock)
    begin
        rd_valid <= rd_req;
        rd_data <= rd_req ? ~rd_addr : ~rd_data;
        if (rst)
            count <= 0;
        else if (wr_valid && wr_ready)
        begin
            count <= count + 1;
            last_data <= wr_data;
            last_addr <= wr_addr;
            last_inc <= wr_inc;
        end
    end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the host port pin block, acting as the host.
// Assumes the DSP-side model in hpb_dsp_model and the checker in hpb_port_props.
`timescale 1ns/1ps
module testbench;
    logic clock = 0, rst = 1, en = 1, sel_lo = 0, sel_hi = 0, cs_n = 1, rw = 0;
    logic ds_a = 0, half = 0, irq_set = 0, irq_clr = 0, stall = 0;
    logic ds_b = 0, strap = 1, astb = 1, use_b = 0;
    logic [7:0] din = 8'h00;
    logic [7:0] dout;
    logic [15:0] q, wr_data, wr_addr, rd_addr, rd_data, ctrl, addr, l_data, l_addr;
    logic d_oe, rdy, rdy_oe, irq, irq_oe, is_host, wr_inc, wr_valid, wr_ready;
    logic rd_req, rd_valid, l_inc;
    int count, fail_count = 0, total_checks = 0, n;
    bit ok;
    always #4 clock = ~clock;
    hpb_port dut (.clock(clock), .rst(rst), .ce(1'b1), .port_enable_pin(en),
        .boot_function_strap(strap), .access_select_lo(sel_lo), .access_select_hi(sel_hi),
        .port_select_n(cs_n), .read_write_select(rw), .data_strobe_a(ds_a),
        .data_strobe_b(ds_b), .byte_half_id(half), .address_strobe_in(astb),
        .host_data_in(din), .host_data_out(dout), .host_data_oe(d_oe),
        .host_ready_out(rdy), .host_ready_oe(rdy_oe), .host_irq_out(irq),
        .host_irq_oe(irq_oe), .shared_line_is_host(is_host), .dsp_irq_set(irq_set),
        .dsp_irq_clear(irq_clr), .wr_data(wr_data), .wr_addr(wr_addr), .wr_inc(wr_inc),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_addr(rd_addr), .rd_req(rd_req),
        .rd_data(rd_data), .rd_valid(rd_valid), .port_control_reg(ctrl),
        .port_address_reg(addr));
    hpb_dsp_model dsp (.clock(clock), .rst(rst), .stall(stall), .wr_data(wr_data),
        .wr_addr(wr_addr), .wr_inc(wr_inc), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .rd_addr(rd_addr), .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid),
        .last_data(l_data), .last_addr(l_addr), .last_inc(l_inc), .count(count));
    task finish_test;
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task check(input logic [15:0] got, input logic [15:0] exp, input string m);
        total_checks++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: %s", $time, m);
            fail_count++;
        end
    endtask
    task wait_ready(output bit r);
        r = 0;
        for (int i = 0; i < 100 && !r; i++)
        begin
            @(negedge clock);
            r = (rdy === 1'b1);
        end
    endtask
    task host_byte(input [1:0] s, input w, input c, input h, input [7:0] d);
        wait_ready(ok);
        if (!ok)
        begin
            check(0, 1, "ready never came");
            finish_test();
        end
        {sel_hi, sel_lo} = s;
        rw = w;
        half = h;
        din = d;
        cs_n = c;
        {ds_b, ds_a} = use_b ? 2'b10 : 2'b01;
        repeat (5) @(negedge clock);
        q = {dout, q[15:8]};
        {ds_b, ds_a} = 2'b00;
        repeat (3) @(negedge clock);
        cs_n = 1;
    endtask
    task addr_strobe(input [7:0] d);
        cs_n = 0;
        din = d;
        astb = 0;
        repeat (4) @(negedge clock);
        astb = 1;
        cs_n = 1;
        repeat (3) @(negedge clock);
    endtask
    task host_word(input [1:0] s, input w, input c, input [15:0] d);
        host_byte(s, w, c, 0, d[7:0]);
        host_byte(s, w, c, 1, d[15:8]);
    endtask
    task t_reset;
        check(rdy_oe, 0, "ready in reset");
        check(irq_oe, 0, "irq in reset");
        rst = 0;
        repeat (5) @(negedge clock);
        check({rdy_oe, rdy, irq_oe, irq}, 16'h000f, "pins after reset");
        check(is_host, 1, "strap");
        $display("reset test done");
    endtask
    task t_regs;
        host_word(0, 0, 0, 16'h0005);
        check(ctrl, 16'h0005, "control write");
        host_word(2, 0, 0, 16'h0040);
        check(addr, 16'h0040, "address write");
        host_word(0, 1, 0, 16'h0000);
        check(q, 16'h0005, "control read");
        host_word(0, 0, 1, 16'hffff);
        check(ctrl, 16'h0005, "write while deselected");
        $display("register test done");
    endtask
    task t_data;
        host_word(1, 0, 0, 16'h1234);
        repeat (8) @(negedge clock);
        check(l_data, 16'h1234, "data word");
        check(l_inc, 1, "incrementing write flag");
        check(l_addr, 16'h0040, "incrementing write address");
        check(addr, 16'h0041, "address after increment");
        host_word(3, 0, 0, 16'habcd);
        repeat (8) @(negedge clock);
        check(l_data, 16'habcd, "plain data write");
        check(l_inc, 0, "plain write flag");
        check(l_addr, 16'h0041, "plain write address");
        check(addr, 16'h0041, "address kept");
        $display("data test done");
    endtask
    task t_read;
        host_word(2, 0, 0, 16'h12ff);
        host_word(1, 1, 0, 16'h0000);
        check(q, 16'h0000, "first data read");
        check(addr, 16'h1300, "address after read increment");
        host_word(3, 1, 0, 16'h0000);
        check(q, 16'hed00, "fetched data word");
        check(addr, 16'h1300, "address kept on plain read");
        $display("read test done");
    endtask
    task t_strap;
        rst = 1;
        strap = 0;
        use_b = 1;
        repeat (6) @(negedge clock);
        check(rdy_oe, 0, "ready in second reset");
        rst = 0;
        repeat (5) @(negedge clock);
        check(is_host, 0, "strap low");
        host_byte(0, 0, 0, 1, 8'h34);
        host_byte(0, 0, 0, 1, 8'h12);
        check(ctrl, 16'h1234, "bytes alternate without byte id");
        addr_strobe(8'h55);
        check(addr, 16'h0000, "address strobe ignored");
        rst = 1;
        strap = 1;
        repeat (6) @(negedge clock);
        rst = 0;
        repeat (5) @(negedge clock);
        check(is_host, 1, "strap high again");
        host_byte(0, 0, 0, 1, 8'h77);
        check(ctrl, 16'h7700, "byte id marks second byte");
        addr_strobe(8'h3c);
        check(addr, 16'h003c, "address strobe latch");
        use_b = 0;
        $display("strap test done");
    endtask
    task t_fifo;
        stall = 1;
        n = count;
        for (int i = 0; i < 20; i++)
        begin
            wait_ready(ok);
            if (ok)
                host_word(1, 0, 0, {8'h5a, i[7:0]});
            else
                break;
        end
        check(ok, 0, "buffer never refused");
        stall = 0;
        repeat (60) @(negedge clock);
        check(count - n >= 16, 1, "words drained");
        check(rdy, 1, "ready after drain");
        $display("buffer test done");
    endtask
    task t_irq;
        irq_set = 1;
        @(negedge clock);
        irq_set = 0;
        repeat (3) @(negedge clock);
        check(irq, 0, "irq raised");
        irq_clr = 1;
        @(negedge clock);
        irq_clr = 0;
        repeat (3) @(negedge clock);
        check(irq, 1, "irq cleared");
        $display("interrupt test done");
    endtask
    task t_disable;
        en = 0;
        repeat (6) @(negedge clock);
        check({rdy_oe, irq_oe, d_oe}, 0, "outputs float");
        en = 1;
        repeat (6) @(negedge clock);
        check(rdy_oe, 1, "ready back");
        $display("enable test done");
    endtask
    initial
    begin
        repeat (6) @(negedge clock);
        t_reset();
        t_regs();
        t_data();
        t_read();
        t_fifo();
        t_irq();
        t_disable();
        t_strap();
        finish_test();
    end
endmodule
bind hpb_port hpb_port_props chk (.clock(clock), .rst(rst), .port_enable_pin(port_enable_pin),
    .boot_function_strap(boot_function_strap), .port_select_n(port_select_n),
    .read_write_select(read_write_select), .host_data_oe(host_data_oe),
    .host_ready_out(host_ready_out), .host_ready_oe(host_ready_oe),
    .host_irq_out(host_irq_out), .host_irq_oe(host_irq_oe),
    .shared_line_is_host(shared_line_is_host), .dsp_irq_set(dsp_irq_set),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready));
